// *** rtl/tidp_regs.svh ***
// constants of the test, init and diagnostic port
`ifndef TIDP_REGS_SVH
`define TIDP_REGS_SVH

// ---------------------------------------------------------------
// serial rom load
// ---------------------------------------------------------------
`define TIDP_SLOW_HALF 8'h80
`define TIDP_FAST_HALF 8'h08
`define TIDP_SR_W 304
`define TIDP_LINE_W 193
`define TIDP_BLOCK_BITS 9'h0c1
`define TIDP_COUNT_BITS 9'h00c
`define TIDP_CFG_BITS 9'h130
`define TIDP_CFG_PAD_BITS 9'h16f
`define TIDP_PAD_BITS (`TIDP_CFG_PAD_BITS - `TIDP_CFG_BITS)
`define TIDP_COUNT_LOW_OK 2'h3

// ---------------------------------------------------------------
// self-test and status pin
// ---------------------------------------------------------------
`define TIDP_BUILTIN_SELF_TEST_CYCLES 700000
`define TIDP_RESULT_LOW 5'h10
`define TIDP_IDLE_LIMIT 12'h800
`define TIDP_TMO_PULSE 2'h3

// ---------------------------------------------------------------
// test access port
// ---------------------------------------------------------------
`define TIDP_IR_SAMPLE 5'h18
`define TIDP_IR_HIGHZ 5'h19
`define TIDP_IR_CLAMP 5'h1a
`define TIDP_IR_EXTEST 5'h1b
`define TIDP_IR_BYPASS 5'h1f
`define TIDP_IR_CAPTURE 5'h01

`endif

// *** rtl/tidp_pkg.sv ***
// types of the test, init and diagnostic port
`include "tidp_regs.svh"
package tidp_pkg;

  // power-up and run phases
  typedef enum logic [6:0] {
    PH_BUILTIN_SELF_TEST = 7'h01,
    PH_RESULT = 7'h02,
    PH_BLOCK = 7'h04,
    PH_COUNT = 7'h08,
    PH_CFG = 7'h10,
    PH_PAD = 7'h20,
    PH_RUN = 7'h40
  } tidp_phase_t;

  // tap controller states
  typedef enum logic [15:0] {
    TS_RESET = 16'h0001,
    TS_IDLE = 16'h0002,
    TS_SEL_DR = 16'h0004,
    TS_CAP_DR = 16'h0008,
    TS_SH_DR = 16'h0010,
    TS_EX1_DR = 16'h0020,
    TS_PA_DR = 16'h0040,
    TS_EX2_DR = 16'h0080,
    TS_UP_DR = 16'h0100,
    TS_SEL_IR = 16'h0200,
    TS_CAP_IR = 16'h0400,
    TS_SH_IR = 16'h0800,
    TS_EX1_IR = 16'h1000,
    TS_PA_IR = 16'h2000,
    TS_EX2_IR = 16'h4000,
    TS_UP_IR = 16'h8000
  } tidp_tap_t;

  // all state of the main block
  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] prev;
    tidp_phase_t ph;
    logic [19:0] cnt;
    logic fast;
    logic [7:0] div;
    logic sclk;
    logic rom_en_n;
    logic int_rst;
    logic array_clear;
    logic [8:0] bitn;
    logic [9:0] blk;
    logic [9:0] nblk;
    logic [9:0] idx;
    logic wr;
    logic [`TIDP_SR_W-1:0] sr;
    logic [11:0] count;
    logic count_err;
    logic cfg_valid;
    logic status;
    logic fail;
    logic [11:0] idle;
    logic [1:0] tmo;
    logic xmit;
    logic xmit_pend;
    logic xmit_val;
    logic rcv;
    logic rx_pend;
    logic trap;
  } tidp_main_t;

  // all state of the tap
  typedef struct packed {
    tidp_tap_t st;
    logic [4:0] ir;
    logic [4:0] ir_sh;
    logic [4:0] mode;
    logic byp;
    logic tdo;
    logic tdo_en;
    logic cap_dr;
    logic sh_dr;
    logic up_dr;
  } tidp_tapreg_t;

endpackage

// *** rtl/tidp_tap.sv ***
// boundary-scan tap controller with instruction and bypass registers
`timescale 1ns/100ps
`include "tidp_regs.svh"
module tidp_tap (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // synchronised tap pins and their edges; bsr_tdo_in comes in unsynchronised
  input wire logic tck_rise_in,
  input wire logic tck_fall_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic trst_n_in,
  input wire logic bsr_tdo_in,
  // scan outputs
  output logic tdo_out,
  output logic tdo_en_out,
  output logic [4:0] ir_out,
  output logic [4:0] mode_out,
  output logic cap_dr_out,
  output logic sh_dr_out,
  output logic up_dr_out
);

  tidp_pkg::tidp_tapreg_t st, n;

  // one-hot {bypass, extest, clamp, highz, sample}; private codes fall to bypass
  function automatic logic [4:0] tidp_mode(input logic [4:0] ir);
    logic [4:0] m;
    m = 5'h10;
    if (ir == `TIDP_IR_SAMPLE) m = 5'h01;
    if (ir == `TIDP_IR_HIGHZ) m = 5'h02;
    if (ir == `TIDP_IR_CLAMP) m = 5'h04;
    if (ir == `TIDP_IR_EXTEST) m = 5'h08;
    return m;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    n = st;
    n.cap_dr = 1'b0;
    n.sh_dr = 1'b0;
    n.up_dr = 1'b0;
    if (!trst_n_in) begin
      n.st = tidp_pkg::TS_RESET;
      n.ir = `TIDP_IR_BYPASS;
      n.mode = tidp_mode(`TIDP_IR_BYPASS);
      n.tdo_en = 1'b0;
    end else if (tck_rise_in) begin
      unique case (st.st)
        tidp_pkg::TS_RESET: n.st = tms_in ? tidp_pkg::TS_RESET : tidp_pkg::TS_IDLE;
        tidp_pkg::TS_IDLE: n.st = tms_in ? tidp_pkg::TS_SEL_DR : tidp_pkg::TS_IDLE;
        tidp_pkg::TS_SEL_DR: n.st = tms_in ? tidp_pkg::TS_SEL_IR : tidp_pkg::TS_CAP_DR;
        tidp_pkg::TS_CAP_DR: n.st = tms_in ? tidp_pkg::TS_EX1_DR : tidp_pkg::TS_SH_DR;
        tidp_pkg::TS_SH_DR: n.st = tms_in ? tidp_pkg::TS_EX1_DR : tidp_pkg::TS_SH_DR;
        tidp_pkg::TS_EX1_DR: n.st = tms_in ? tidp_pkg::TS_UP_DR : tidp_pkg::TS_PA_DR;
        tidp_pkg::TS_PA_DR: n.st = tms_in ? tidp_pkg::TS_EX2_DR : tidp_pkg::TS_PA_DR;
        tidp_pkg::TS_EX2_DR: n.st = tms_in ? tidp_pkg::TS_UP_DR : tidp_pkg::TS_SH_DR;
        tidp_pkg::TS_UP_DR: n.st = tms_in ? tidp_pkg::TS_SEL_DR : tidp_pkg::TS_IDLE;
        tidp_pkg::TS_SEL_IR: n.st = tms_in ? tidp_pkg::TS_RESET : tidp_pkg::TS_CAP_IR;
        tidp_pkg::TS_CAP_IR: n.st = tms_in ? tidp_pkg::TS_EX1_IR : tidp_pkg::TS_SH_IR;
        tidp_pkg::TS_SH_IR: n.st = tms_in ? tidp_pkg::TS_EX1_IR : tidp_pkg::TS_SH_IR;
        tidp_pkg::TS_EX1_IR: n.st = tms_in ? tidp_pkg::TS_UP_IR : tidp_pkg::TS_PA_IR;
        tidp_pkg::TS_PA_IR: n.st = tms_in ? tidp_pkg::TS_EX2_IR : tidp_pkg::TS_PA_IR;
        tidp_pkg::TS_EX2_IR: n.st = tms_in ? tidp_pkg::TS_UP_IR : tidp_pkg::TS_SH_IR;
        tidp_pkg::TS_UP_IR: n.st = tms_in ? tidp_pkg::TS_SEL_DR : tidp_pkg::TS_IDLE;
      endcase
      // capture and shift act on the rising test clock
      if (st.st == tidp_pkg::TS_CAP_IR) n.ir_sh = `TIDP_IR_CAPTURE;
      if (st.st == tidp_pkg::TS_SH_IR) n.ir_sh = {tdi_in, st.ir_sh[4:1]};
      if (st.st == tidp_pkg::TS_CAP_DR) begin
        n.byp = 1'b0;
        n.cap_dr = 1'b1;
      end
      if (st.st == tidp_pkg::TS_SH_DR) begin
        n.byp = tdi_in;
        n.sh_dr = 1'b1;
      end
    end else if (tck_fall_in) begin
      // tdo and updates move on the falling test clock
      n.tdo_en = 1'b0;
      if (st.st == tidp_pkg::TS_SH_IR) begin
        n.tdo = st.ir_sh[0];
        n.tdo_en = 1'b1;
      end
      if (st.st == tidp_pkg::TS_SH_DR) begin
        n.tdo = (st.mode[0] | st.mode[3]) ? bsr_tdo_in : st.byp;
        n.tdo_en = 1'b1;
      end
      if (st.st == tidp_pkg::TS_UP_IR) begin
        n.ir = st.ir_sh;
        n.mode = tidp_mode(st.ir_sh);
      end
      if (st.st == tidp_pkg::TS_RESET) begin
        n.ir = `TIDP_IR_BYPASS;
        n.mode = tidp_mode(`TIDP_IR_BYPASS);
      end
      n.up_dr = (st.st == tidp_pkg::TS_UP_DR);
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= '0;
      st.st <= tidp_pkg::TS_RESET;
      st.ir <= `TIDP_IR_BYPASS;
      st.mode <= 5'h10;
    end else begin
      st <= n;
    end
  end

  assign tdo_out = st.tdo;
  assign tdo_en_out = st.tdo_en;
  assign ir_out = st.ir;
  assign mode_out = st.mode;
  assign cap_dr_out = st.cap_dr;
  assign sh_dr_out = st.sh_dr;
  assign up_dr_out = st.up_dr;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_bypass_shift: assert property (
    @(posedge clk_in) disable iff (rst_in)
    trst_n_in && tck_rise_in && st.st == tidp_pkg::TS_SH_DR |=> st.byp == $past(tdi_in))
    else $error("bypass stage did not take tdi");
  chk_ir_update: assert property (
    @(posedge clk_in) disable iff (rst_in)
    trst_n_in && tck_fall_in && st.st == tidp_pkg::TS_UP_IR && st.ir_sh == `TIDP_IR_EXTEST
    |=> st.ir == `TIDP_IR_EXTEST && st.mode == 5'h08)
    else $error("extest not decoded on update");
  chk_tap_walk: assert property (
    @(posedge clk_in) disable iff (rst_in)
    trst_n_in && tck_rise_in && st.st == tidp_pkg::TS_IDLE && tms_in
    |=> st.st == tidp_pkg::TS_SEL_DR)
    else $error("tap did not follow tms");

endmodule

// *** rtl/tidp_top.sv ***
// power-up self-test, serial rom loader, serial terminal and tap
`timescale 1ns/100ps
`include "tidp_regs.svh"
module tidp_top #(
  parameter int BUILTIN_SELF_TEST_CYCLES = `TIDP_BUILTIN_SELF_TEST_CYCLES
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // serial rom and terminal pins
  input wire logic SERIAL_DATA_IN,
  output logic SERIAL_CLOCK_OUT,
  output logic ROM_ENABLE_N_OUT,
  // load configuration
  input wire logic FAST_LOAD_FLAG_IN,
  input wire logic [9:0] FETCH_BLOCKS_IN,
  // loaded image
  output logic ICACHE_WR_OUT,
  output logic [9:0] ICACHE_IDX_OUT,
  output logic [`TIDP_LINE_W-1:0] ICACHE_LINE_OUT,
  output logic [11:0] FETCH_COUNT_OUT,
  output logic COUNT_ERR_OUT,
  output logic [`TIDP_SR_W-1:0] CFG_DATA_OUT,
  output logic CFG_VALID_OUT,
  // self-test and core side
  input wire logic BUILTIN_SELF_TEST_FAIL_IN,
  input wire logic INSTR_RETIRE_IN,
  input wire logic XMIT_WR_IN,
  input wire logic XMIT_DATA_IN,
  input wire logic WR_RETIRE_IN,
  input wire logic PRIVILEGED_MODE_IN,
  output logic ARRAY_CLEAR_OUT,
  output logic INTERNAL_RESET_OUT,
  output logic SELFTEST_FAIL_BIT_OUT,
  output logic SELFTEST_STATUS_PIN_OUT,
  output logic RECEIVE_BIT_OUT,
  output logic RX_TRAP_OUT,
  // test access port
  input wire logic TCK_IN,
  input wire logic TMS_IN,
  input wire logic TDI_IN,
  input wire logic TRST_N_IN,
  input wire logic BSR_TDO_IN,
  output logic TDO_OUT,
  output logic TDO_EN_OUT,
  output logic [4:0] IR_OUT,
  output logic [4:0] MODE_OUT,
  output logic CAPTURE_DR_OUT,
  output logic SHIFT_DR_OUT,
  output logic UPDATE_DR_OUT
);

  // the self-test counter is 20 bits wide
  if (BUILTIN_SELF_TEST_CYCLES < 1 || BUILTIN_SELF_TEST_CYCLES > 1048576) begin : g_bad_builtin_self_test
    $error("BUILTIN_SELF_TEST_CYCLES out of range");
  end

  tidp_pkg::tidp_main_t st, n;
  logic [7:0] half;
  logic in_load;
  logic tck_rise;
  logic tck_fall;
  logic fire;
  logic [7:0] hc_ff;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  assign half = st.fast ? `TIDP_FAST_HALF : `TIDP_SLOW_HALF;
  assign in_load = st.ph == tidp_pkg::PH_BLOCK || st.ph == tidp_pkg::PH_COUNT ||
                   st.ph == tidp_pkg::PH_CFG || st.ph == tidp_pkg::PH_PAD;
  assign tck_rise = st.sync2[1] & ~st.prev[1];
  assign tck_fall = ~st.sync2[1] & st.prev[1];
  assign fire = st.rx_pend && !PRIVILEGED_MODE_IN;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    n = st;
    // pins cross in through two flops; prev only feeds edge detection
    n.sync1 = {TRST_N_IN, TDI_IN, TMS_IN, TCK_IN, SERIAL_DATA_IN};
    n.sync2 = st.sync1;
    n.prev = st.sync2;
    n.rcv = st.sync2[0];
    n.wr = 1'b0;
    n.trap = 1'b0;
    unique case (st.ph)
      tidp_pkg::PH_BUILTIN_SELF_TEST: begin
        n.status = 1'b1;
        n.array_clear = 1'b1;
        n.cnt = st.cnt + 20'h00001;
        if (st.cnt == 20'(BUILTIN_SELF_TEST_CYCLES - 1)) begin
          n.fail = BUILTIN_SELF_TEST_FAIL_IN;
          n.array_clear = 1'b0;
          n.status = 1'b0;
          n.cnt = '0;
          n.ph = tidp_pkg::PH_RESULT;
        end
      end
      tidp_pkg::PH_RESULT: begin
        n.cnt = st.cnt + 20'h00001;
        if (st.cnt[4:0] == `TIDP_RESULT_LOW - 5'h01) begin
          n.status = st.fail;
          n.rom_en_n = 1'b0;
          n.fast = FAST_LOAD_FLAG_IN;
          n.nblk = FETCH_BLOCKS_IN;
          n.div = '0;
          n.bitn = '0;
          n.blk = '0;
          // an empty block count skips straight to the count field
          n.ph = (FETCH_BLOCKS_IN == 10'h000) ? tidp_pkg::PH_COUNT : tidp_pkg::PH_BLOCK;
        end
      end
      tidp_pkg::PH_BLOCK, tidp_pkg::PH_COUNT, tidp_pkg::PH_CFG, tidp_pkg::PH_PAD: begin
        n.div = st.div + 8'h01;
        if (st.div == half - 8'h01) begin
          n.div = '0;
          n.sclk = ~st.sclk;
          if (!st.sclk) begin
            // rising edge: rom advances, we take the bit it held
            n.bitn = st.bitn + 9'h001;
            // padding is not kept so the config word survives in place
            if (st.ph != tidp_pkg::PH_PAD) n.sr = {st.sr[`TIDP_SR_W-2:0], st.sync2[0]};
            if (st.ph == tidp_pkg::PH_BLOCK && st.bitn == `TIDP_BLOCK_BITS - 9'h001) begin
              n.wr = 1'b1;
              n.idx = st.blk;
              n.blk = st.blk + 10'h001;
              n.bitn = '0;
              if (st.blk == st.nblk - 10'h001) n.ph = tidp_pkg::PH_COUNT;
            end
            if (st.ph == tidp_pkg::PH_COUNT && st.bitn == `TIDP_COUNT_BITS - 9'h001) begin
              n.count = n.sr[11:0];
              n.count_err = n.sr[1:0] != `TIDP_COUNT_LOW_OK;
              n.bitn = '0;
              n.ph = tidp_pkg::PH_CFG;
            end
            if (st.ph == tidp_pkg::PH_CFG && st.bitn == `TIDP_CFG_BITS - 9'h001) begin
              n.cfg_valid = 1'b1;
              n.bitn = '0;
              n.ph = tidp_pkg::PH_PAD;
            end
          end else if (st.ph == tidp_pkg::PH_PAD && st.bitn == `TIDP_PAD_BITS) begin
            // last falling edge closes the load at once; the pin then follows the transmit bit
            n.rom_en_n = 1'b1;
            n.int_rst = 1'b0;
            n.sclk = st.xmit;
            n.ph = tidp_pkg::PH_RUN;
          end
        end
      end
      tidp_pkg::PH_RUN: begin
        n.sclk = st.xmit;
        // a write waits for its own retirement before it shows
        if (st.xmit_pend && WR_RETIRE_IN) begin
          n.xmit = st.xmit_val;
          n.xmit_pend = 1'b0;
        end
        if (XMIT_WR_IN) begin
          n.xmit_pend = 1'b1;
          n.xmit_val = XMIT_DATA_IN;
        end
        // a new edge wins over the hand-off of an older one
        n.trap = fire;
        n.rx_pend = (st.sync2[0] != st.rcv) || (st.rx_pend && !fire);
        if (st.tmo != 2'h0) n.tmo = st.tmo - 2'h1;
        if (INSTR_RETIRE_IN) begin
          n.idle = '0;
        end else if (st.idle == `TIDP_IDLE_LIMIT - 12'h001) begin
          n.idle = '0;
          n.tmo = `TIDP_TMO_PULSE;
        end else begin
          n.idle = st.idle + 12'h001;
        end
        n.status = st.fail || n.tmo != 2'h0;
      end
    endcase
  end

  // state register, synchronous reset
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      st <= '0;
      st.ph <= tidp_pkg::PH_BUILTIN_SELF_TEST;
      st.rom_en_n <= 1'b1;
      st.int_rst <= 1'b1;
      st.sync1 <= 5'h10;
      st.sync2 <= 5'h10;
      st.prev <= 5'h10;
    end else begin
      st <= n;
    end
  end

  // ---------------------------------------------------------------
  // tap
  // ---------------------------------------------------------------
  tidp_tap u_tap (
    .clk_in(CLK_IN),
    .rst_in(RESET_IN),
    .tck_rise_in(tck_rise),
    .tck_fall_in(tck_fall),
    .tms_in(st.sync2[2]),
    .tdi_in(st.sync2[3]),
    .trst_n_in(st.sync2[4]),
    .bsr_tdo_in(BSR_TDO_IN),
    .tdo_out(TDO_OUT),
    .tdo_en_out(TDO_EN_OUT),
    .ir_out(IR_OUT),
    .mode_out(MODE_OUT),
    .cap_dr_out(CAPTURE_DR_OUT),
    .sh_dr_out(SHIFT_DR_OUT),
    .up_dr_out(UPDATE_DR_OUT)
  );

  // outputs, all from flops
  assign SERIAL_CLOCK_OUT = st.sclk;
  assign ROM_ENABLE_N_OUT = st.rom_en_n;
  assign ICACHE_WR_OUT = st.wr;
  assign ICACHE_IDX_OUT = st.idx;
  assign ICACHE_LINE_OUT = st.sr[`TIDP_LINE_W-1:0];
  assign FETCH_COUNT_OUT = st.count;
  assign COUNT_ERR_OUT = st.count_err;
  assign CFG_DATA_OUT = st.sr;
  assign CFG_VALID_OUT = st.cfg_valid;
  assign ARRAY_CLEAR_OUT = st.array_clear;
  assign INTERNAL_RESET_OUT = st.int_rst;
  assign SELFTEST_FAIL_BIT_OUT = st.fail;
  assign SELFTEST_STATUS_PIN_OUT = st.status;
  assign RECEIVE_BIT_OUT = st.rcv;
  assign RX_TRAP_OUT = st.trap;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // cycles since the serial clock last moved, restarted on load entry
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN || n.sclk != st.sclk || st.ph == tidp_pkg::PH_RESULT) begin
      hc_ff <= '0;
    end else begin
      hc_ff <= hc_ff + 8'h01;
    end
  end

  chk_sclk_half: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    in_load && $past(in_load) && $changed(st.sclk) |-> $past(hc_ff) == half - 8'h01)
    else $error("serial clock half period wrong");
  chk_rom_enable: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    (in_load |-> !ROM_ENABLE_N_OUT) and (st.ph == tidp_pkg::PH_RUN |-> ROM_ENABLE_N_OUT))
    else $error("rom enable wrong for phase");
  chk_xmit_retire: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    $changed(st.xmit) |-> $past(WR_RETIRE_IN) && $past(st.xmit_pend))
    else $error("transmit bit moved without retirement");
  chk_xmit_pin: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    st.ph == tidp_pkg::PH_RUN && $past(st.ph) == tidp_pkg::PH_RUN
    |-> SERIAL_CLOCK_OUT == $past(st.xmit))
    else $error("serial clock pin not following transmit bit");
  chk_rx_trap: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    st.ph == tidp_pkg::PH_RUN && st.sync2[0] != st.rcv ##1 !PRIVILEGED_MODE_IN |-> ##1 RX_TRAP_OUT)
    else $error("receive edge gave no trap");
  chk_priv_block: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    RX_TRAP_OUT |-> !$past(PRIVILEGED_MODE_IN))
    else $error("trap while privileged");
  chk_result_low: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    $rose(st.ph == tidp_pkg::PH_RESULT) |-> (!st.status)[*8] ##1 (!st.status)[*8]
    ##1 st.status == st.fail)
    else $error("result interval wrong");
  chk_timeout_pulse: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    st.ph == tidp_pkg::PH_RUN && !st.fail && $rose(st.status) |-> st.status[*3] ##1 !st.status)
    else $error("timeout pulse not three cycles");
  chk_builtin_self_test_hold: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    $past(st.ph) != tidp_pkg::PH_RUN |-> INTERNAL_RESET_OUT || st.ph == tidp_pkg::PH_RUN)
    else $error("internal reset released early");
  chk_fail_sticky: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    $past(st.fail) && st.ph == tidp_pkg::PH_RUN |-> st.fail && st.status)
    else $error("fail status dropped");

endmodule

// *** test/tidp_rom_model.sv ***
// serial rom model that feeds the loader one image bit per serial clock
`timescale 1ns/100ps
module tidp_rom_model #(
  parameter int BITS = 958
) (
  // clock
  input wire logic clk_in,
  // rom pins and image
  input wire logic rom_enable_n_in,
  input wire logic serial_clock_in,
  input wire logic [BITS-1:0] image_in,
  output logic data_out,
  output logic drive_out
);
  int ptr = 0;
  int hold = 0;
  logic clk_q = 1'b0;
  logic last = 1'b0;
  // advance only once the hold after each clock rise has run out
  always @(posedge clk_in) begin
    clk_q <= serial_clock_in;
    if (rom_enable_n_in) begin
      ptr <= 0;
    end else if (serial_clock_in && !clk_q) begin
      hold <= 3;
    end else if (hold != 0) begin
      hold <= hold - 1;
      if (hold == 1) ptr <= ptr + 1;
    end
    if (!rom_enable_n_in && ptr < BITS) last <= image_in[ptr];
  end
  // past its end the rom holds its final bit; released, the line shows the inverse
  assign data_out = rom_enable_n_in ? ~last : (ptr < BITS) ? image_in[ptr] : last;
  assign drive_out = !rom_enable_n_in;
endmodule

// *** test/tb_top.sv ***
// testbench of the test, init and diagnostic port
`timescale 1ns/100ps
module tb_top;
  localparam int NB = 3;
  localparam int CB = NB * 193;
  localparam int NBITS = CB + 379;
  localparam logic [7:0] PAT = 8'hb4;
  logic CLK_IN = 1'b0, RESET_IN = 1'b1, BUILTIN_SELF_TEST_FAIL_IN = 1'b0, INSTR_RETIRE_IN = 1'b1;
  logic XMIT_WR_IN = 1'b0, XMIT_DATA_IN = 1'b0, WR_RETIRE_IN = 1'b0, PRIVILEGED_MODE_IN = 1'b0;
  logic TCK_IN = 1'b0, TMS_IN = 1'b1, TDI_IN = 1'b0, rx_line = 1'b0, rom_data, rom_drive;
  logic FAST_LOAD_FLAG_IN = 1'b1;
  logic [9:0] FETCH_BLOCKS_IN = 10'h003;
  logic SERIAL_CLOCK_OUT, ROM_ENABLE_N_OUT, ICACHE_WR_OUT, COUNT_ERR_OUT, CFG_VALID_OUT;
  logic ARRAY_CLEAR_OUT, INTERNAL_RESET_OUT, SELFTEST_FAIL_BIT_OUT, SELFTEST_STATUS_PIN_OUT;
  logic RECEIVE_BIT_OUT, RX_TRAP_OUT, TDO_OUT, TDO_EN_OUT, CAPTURE_DR_OUT, SHIFT_DR_OUT;
  logic UPDATE_DR_OUT;
  logic [9:0] ICACHE_IDX_OUT;
  logic [192:0] ICACHE_LINE_OUT;
  logic [11:0] FETCH_COUNT_OUT;
  logic [303:0] CFG_DATA_OUT, cfg;
  logic [4:0] IR_OUT, MODE_OUT;
  logic [4:0] ops [6] = '{5'h18, 5'h19, 5'h1a, 5'h1b, 5'h1f, 5'h1f};
  logic [4:0] modes [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h10};
  logic [NBITS-1:0] image;
  wire SERIAL_DATA_IN = rom_drive ? rom_data : rx_line;
  int err_total = 0, comparisons = 0, blk = 0, traps = 0, n, i;
  int caps = 0, shifts = 0, ups = 0;

  tidp_top #(.BUILTIN_SELF_TEST_CYCLES(20)) dut (.CLK_IN, .RESET_IN, .SERIAL_DATA_IN, .SERIAL_CLOCK_OUT,
    .ROM_ENABLE_N_OUT, .FAST_LOAD_FLAG_IN, .FETCH_BLOCKS_IN, .ICACHE_WR_OUT,
    .ICACHE_IDX_OUT, .ICACHE_LINE_OUT, .FETCH_COUNT_OUT, .COUNT_ERR_OUT, .CFG_DATA_OUT,
    .CFG_VALID_OUT, .BUILTIN_SELF_TEST_FAIL_IN, .INSTR_RETIRE_IN, .XMIT_WR_IN, .XMIT_DATA_IN, .WR_RETIRE_IN,
    .PRIVILEGED_MODE_IN, .ARRAY_CLEAR_OUT, .INTERNAL_RESET_OUT, .SELFTEST_FAIL_BIT_OUT,
    .SELFTEST_STATUS_PIN_OUT, .RECEIVE_BIT_OUT, .RX_TRAP_OUT, .TCK_IN, .TMS_IN, .TDI_IN,
    .TRST_N_IN(1'b1), .BSR_TDO_IN(1'b0), .TDO_OUT, .TDO_EN_OUT, .IR_OUT, .MODE_OUT,
    .CAPTURE_DR_OUT, .SHIFT_DR_OUT, .UPDATE_DR_OUT);
  tidp_rom_model #(.BITS(NBITS)) rom (.clk_in(CLK_IN), .rom_enable_n_in(ROM_ENABLE_N_OUT),
    .serial_clock_in(SERIAL_CLOCK_OUT), .image_in(image), .data_out(rom_data),
    .drive_out(rom_drive));

  always #10 CLK_IN = ~CLK_IN;

  task automatic check(input logic [303:0] got, input logic [303:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge CLK_IN);
  endtask

  function automatic logic [192:0] line_of(input int k);
    for (int j = 0; j < 193; j++) line_of[192 - j] = image[k * 193 + j];
  endfunction

  // one test clock: long low phase so tdo has settled before the rise
  task automatic tck(input logic ms, input logic di, output logic dout);
    TMS_IN = ms;
    TDI_IN = di;
    #100 dout = TDO_OUT;
    TCK_IN = 1'b1;
    #60 TCK_IN = 1'b0;
  endtask

  task automatic walk(input logic [15:0] ms, input int k);
    logic d;
    for (int j = 0; j < k; j++) tck(ms[j], 1'b0, d);
  endtask

  task automatic load_ir(input logic [4:0] op);
    logic d;
    walk(16'h00df, 10);
    for (int j = 0; j < 5; j++) tck(j == 4, op[j], d);
    walk(16'h0001, 2);
    #400;
  endtask

  // block monitor: each written line must be the next block of the image
  always @(negedge CLK_IN) begin
    if (RX_TRAP_OUT === 1'b1) traps++;
    if (CAPTURE_DR_OUT === 1'b1) caps++;
    if (SHIFT_DR_OUT === 1'b1) shifts++;
    if (UPDATE_DR_OUT === 1'b1) ups++;
    if (ICACHE_WR_OUT === 1'b1) begin
      check(ICACHE_IDX_OUT, blk);
      check(ICACHE_LINE_OUT, line_of(blk));
      blk++;
    end
  end

  // watchdog, generous against about 22k cycles of tests
  initial begin
    #1000000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    logic d;
    for (i = 0; i < NBITS; i++) image[i] = (i < CB) ? ((i * 5) % 7 < 3) : ((i * 3) % 5 < 2);
    for (i = 0; i < 12; i++) image[CB + i] = (i >= 10);
    for (i = CB + 316; i < NBITS; i++) image[i] = 1'b0;
    for (i = 0; i < 304; i++) cfg[303 - i] = image[CB + 12 + i];
    cyc(4);
    RESET_IN = 1'b0;
    cyc(3);
    check(SELFTEST_STATUS_PIN_OUT, 1'b1);
    check(ARRAY_CLEAR_OUT, 1'b1);
    check(INTERNAL_RESET_OUT, 1'b1);
    for (n = 0; n < 40 && SELFTEST_STATUS_PIN_OUT === 1'b1; n++) cyc(1);
    cyc(16);
    check(ROM_ENABLE_N_OUT, 1'b0);
    check(SELFTEST_STATUS_PIN_OUT, 1'b0);
    check(SELFTEST_FAIL_BIT_OUT, 1'b0);
    $display("selftest pass test done");
    for (n = 0; n < 200 && SERIAL_CLOCK_OUT !== 1'b1; n++) cyc(1);
    for (n = 0; n < 20 && SERIAL_CLOCK_OUT === 1'b1; n++) cyc(1);
    check(n, 8);
    for (n = 0; n < 20 && SERIAL_CLOCK_OUT === 1'b0; n++) cyc(1);
    check(n, 8);
    for (n = 0; n < 20000 && ROM_ENABLE_N_OUT !== 1'b1; n++) cyc(1);
    check(blk, NB);
    check(CFG_VALID_OUT, 1'b1);
    check(CFG_DATA_OUT, cfg);
    check(FETCH_COUNT_OUT, 12'h003);
    check(COUNT_ERR_OUT, 1'b0);
    check(INTERNAL_RESET_OUT, 1'b0);
    check(SERIAL_CLOCK_OUT, 1'b0);
    $display("serial load test done");
    XMIT_DATA_IN = 1'b1;
    XMIT_WR_IN = 1'b1;
    cyc(1);
    XMIT_WR_IN = 1'b0;
    cyc(4);
    check(SERIAL_CLOCK_OUT, 1'b0);
    WR_RETIRE_IN = 1'b1;
    cyc(1);
    WR_RETIRE_IN = 1'b0;
    cyc(2);
    check(SERIAL_CLOCK_OUT, 1'b1);
    rx_line = 1'b1;
    cyc(8);
    check(traps, 1);
    check(RECEIVE_BIT_OUT, 1'b1);
    PRIVILEGED_MODE_IN = 1'b1;
    rx_line = 1'b0;
    cyc(8);
    check(traps, 1);
    PRIVILEGED_MODE_IN = 1'b0;
    cyc(4);
    check(traps, 2);
    INSTR_RETIRE_IN = 1'b0;
    for (n = 0; n < 2100 && SELFTEST_STATUS_PIN_OUT !== 1'b1; n++) cyc(1);
    check(n > 2040 && n < 2052, 1'b1);
    for (n = 0; n < 9 && SELFTEST_STATUS_PIN_OUT === 1'b1; n++) cyc(1);
    check(n, 3);
    INSTR_RETIRE_IN = 1'b1;
    $display("terminal and timeout test done");
    for (i = 0; i < 6; i++) begin
      load_ir(ops[i]);
      check(MODE_OUT, modes[i]);
      check(IR_OUT, ops[i]);
    end
    walk(16'h0001, 3);
    for (i = 0; i < 8; i++) begin
      tck(1'b0, PAT[i], d);
      if (i > 0) check(d, PAT[i - 1]);
      check(TDO_EN_OUT, 1'b1);
    end
    // leave shift through update so the strobe pulses are seen too
    walk(16'h0003, 2);
    #100;
    check(caps, 1);
    check(shifts, 9);
    check(ups, 1);
    $display("tap test done");
    @(negedge CLK_IN);
    blk = 0;
    BUILTIN_SELF_TEST_FAIL_IN = 1'b1;
    // second run: slow clock, no blocks, stream opens at the count field
    FAST_LOAD_FLAG_IN = 1'b0;
    FETCH_BLOCKS_IN = 10'h000;
    image = image >> CB;
    RESET_IN = 1'b1;
    cyc(4);
    RESET_IN = 1'b0;
    cyc(3);
    for (n = 0; n < 40 && SELFTEST_STATUS_PIN_OUT === 1'b1; n++) cyc(1);
    for (n = 0; n < 40 && SELFTEST_STATUS_PIN_OUT === 1'b0; n++) cyc(1);
    check(n, 16);
    check(SELFTEST_FAIL_BIT_OUT, 1'b1);
    cyc(100);
    check(SELFTEST_STATUS_PIN_OUT, 1'b1);
    $display("selftest fail test done");
    for (n = 0; n < 200 && SERIAL_CLOCK_OUT !== 1'b1; n++) cyc(1);
    for (n = 0; n < 300 && SERIAL_CLOCK_OUT === 1'b1; n++) cyc(1);
    check(n, 128);
    for (n = 0; n < 3000 && FETCH_COUNT_OUT !== 12'h003; n++) cyc(1);
    check(FETCH_COUNT_OUT, 12'h003);
    check(COUNT_ERR_OUT, 1'b0);
    check(blk, 0);
    $display("slow empty load test done");
    tally_and_finish();
  end
endmodule
